// file: hdl/sadec_ecc_top.sv
// Checkbit generation on writes and check/correct on reads; data bit 50 shares column 8'h10 with checkbit 4
`timescale 1ns/10ps
module sadec_ecc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Write side
  input wire logic [sadec_pkg::WORD_W-1:0] wrEvenWordData,
  input wire logic [sadec_pkg::WORD_W-1:0] wrOddWordData,
  input wire logic [31:0] wrAddr,
  output logic [sadec_pkg::CHK_W-1:0] wrChkBits,
  // Read request
  input wire logic rdValid,
  input wire logic [sadec_pkg::WORD_W-1:0] rdEvenWordData,
  input wire logic [sadec_pkg::WORD_W-1:0] rdOddWordData,
  input wire logic [31:0] rdAddr,
  input wire logic [sadec_pkg::CHK_W-1:0] rdChkBits,
  // Read answer
  output logic rdDone,
  output logic [sadec_pkg::DATA_W-1:0] rdData,
  output logic rdCorrected,
  output logic rdUncorrectable,
  output logic [sadec_pkg::CHK_W-1:0] rdSyndrome
);
  import sadec_pkg::*;

  // Single set bit: syndrome points at a checkbit
  function automatic logic isCheckCol(input logic [7:0] s);
    isCheckCol = (s != CHK_RST) && ((s & (s - 8'h01)) == CHK_RST);
  endfunction

  // Mask of data bits whose column equals the syndrome
  function automatic logic [63:0] dataHit(input logic [7:0] s);
    logic [63:0] m;
    m = DATA_RST;
    for (int i = 0; i < DATA_W; i++) begin
      if (s != CHK_RST && DATA_COL[i] == s) begin
        m[i] = 1'b1;
      end
    end
    dataHit = m;
  endfunction

  sadec_enc_if wrBus ();
  sadec_enc_if rdBus ();

  // Doubleword assembly, byte-select bits dropped
  assign wrBus.data = {wrEvenWordData, wrOddWordData};
  assign wrBus.addr = wrAddr[ADDR_HI:ADDR_LO];
  assign rdBus.data = {rdEvenWordData, rdOddWordData};
  assign rdBus.addr = rdAddr[ADDR_HI:ADDR_LO];

  sadec_encoder wrEnc (
    .port (wrBus.enc)
  );

  sadec_encoder rdEnc (
    .port (rdBus.enc)
  );

  // Same-cycle checkbits for the store
  assign wrChkBits = wrBus.chk;

  sadec_rd_s state_r;
  sadec_rd_s state_nxt;
  logic [7:0] syn;
  logic [63:0] hit;

  assign syn = rdBus.chk ^ rdChkBits;
  assign hit = dataHit(syn);

  always_comb begin
    state_nxt = state_r;
    state_nxt.done = rdValid;
    if (rdValid) begin
      state_nxt.syndrome = syn;
      state_nxt.data = rdBus.data;
      state_nxt.corrected = 1'b0;
      state_nxt.uncorrectable = 1'b0;
      if (syn == CHK_RST) begin
        state_nxt.data = rdBus.data;
      end else if (hit != DATA_RST) begin
        state_nxt.data = rdBus.data ^ hit;
        state_nxt.corrected = 1'b1;
      end else if (isCheckCol(syn)) begin
        state_nxt.corrected = 1'b1;
      end else begin
        state_nxt.uncorrectable = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rdDone = state_r.done;
  assign rdData = state_r.data;
  assign rdCorrected = state_r.corrected;
  assign rdUncorrectable = state_r.uncorrectable;
  assign rdSyndrome = state_r.syndrome;
endmodule

// file: hdl/sadec_pkg.sv
// Shared constants and types for the address/data checkbit block
package sadec_pkg;

  localparam int DATA_W = 64;
  localparam int ADDR_HI = 31;
  localparam int ADDR_LO = 3;
  localparam int CHK_W = 8;
  localparam int WORD_W = 32;

  // Data columns, element 63 first
  localparam logic [63:0][7:0] DATA_COL = {
    8'hB0, 8'h23, 8'h70, 8'h62, 8'h85, 8'h13, 8'h45, 8'h52,
    8'h2A, 8'h8A, 8'h0B, 8'h0E, 8'hF8, 8'h10, 8'hD9, 8'hA1,
    8'h54, 8'hA7, 8'hA8, 8'h92, 8'hC8, 8'h07, 8'h34, 8'h32,
    8'h68, 8'h89, 8'h98, 8'h49, 8'h61, 8'h86, 8'h91, 8'h46,
    8'h58, 8'h4F, 8'h38, 8'h75, 8'hC4, 8'h0D, 8'hA4, 8'h37,
    8'h64, 8'h16, 8'h94, 8'h29, 8'hEA, 8'h26, 8'h1A, 8'h19,
    8'hD0, 8'hC2, 8'h2C, 8'h51, 8'hE0, 8'hA2, 8'h1C, 8'h31,
    8'h8C, 8'h4A, 8'h4C, 8'h15, 8'h83, 8'h9E, 8'h43, 8'hC1
  };

  // Address columns, element 31 first
  localparam logic [31:3][7:0] ADDR_COL = {
    8'h1F, 8'hF4, 8'h3B, 8'hE3, 8'h5D, 8'hDA, 8'h6E, 8'hB5,
    8'h8F, 8'hD6, 8'h79, 8'hBA, 8'h9B, 8'hE5, 8'h57, 8'hEC,
    8'hC7, 8'hAE, 8'h67, 8'h9D, 8'h5B, 8'hE6, 8'h3E, 8'hF1,
    8'hDC, 8'hE9, 8'h3D, 8'hF2, 8'h2F
  };

  localparam logic [7:0] CHK_RST = 8'h00;
  localparam logic [63:0] DATA_RST = 64'h0000_0000_0000_0000;

  typedef struct packed {
    logic done;
    logic corrected;
    logic uncorrectable;
    logic [7:0] syndrome;
    logic [63:0] data;
  } sadec_rd_s;

endpackage

// file: hdl/sadec_enc_if.sv
// Carrier between the top and the checkbit encoder
`timescale 1ns/10ps
interface sadec_enc_if;
  logic [63:0] data;
  logic [31:3] addr;
  logic [7:0] chk;
  modport enc (input data, input addr, output chk);
  modport user (output data, output addr, input chk);
endinterface

// file: hdl/sadec_encoder.sv
// Combinational column-XOR checkbit generator
`timescale 1ns/10ps
module sadec_encoder (
  // Operands and result
  sadec_enc_if.enc port
);
  import sadec_pkg::*;

  logic [7:0] dataPart;
  logic [7:0] addrPart;

  always_comb begin
    dataPart = CHK_RST;
    addrPart = CHK_RST;
    for (int i = 0; i < DATA_W; i++) begin
      if (port.data[i]) begin
        dataPart = dataPart ^ DATA_COL[i];
      end
    end
    for (int j = ADDR_LO; j <= ADDR_HI; j++) begin
      if (port.addr[j]) begin
        addrPart = addrPart ^ ADDR_COL[j];
      end
    end
  end

  assign port.chk = dataPart ^ addrPart;
endmodule

// file: verif/sadec_mem_model.sv
// Memory cell keeping one doubleword and its checkbits
`timescale 1ns/10ps
module sadec_mem_model (
  // Write side and checkbit upsets
  input wire logic clk, wr,
  input wire logic [31:0] wrEvenWordData, wrOddWordData,
  input wire logic [7:0] wrChkBits, flipChk,
  // Upsets laid over the stored word
  input wire logic [63:0] flip,
  // Read-back
  output logic [31:0] rdEvenWordData, rdOddWordData,
  output logic [7:0] rdChkBits
);
  logic [71:0] cell_r = '0;
  always_ff @(posedge clk) if (wr)
    cell_r <= {wrEvenWordData, wrOddWordData, wrChkBits};
  assign {rdEvenWordData, rdOddWordData, rdChkBits} =
    cell_r ^ {flip, flipChk};
endmodule

// file: verif/sadec_ecc_sva.sv
// Port checks for the ECC top
`timescale 1ns/10ps
module sadec_ecc_sva (
  // Watched ports
  input wire logic clk, sys_rst, rdValid, rdDone,
  input wire logic rdCorrected, rdUncorrectable,
  input wire logic [31:0] wrEvenWordData, wrOddWordData, wrAddr,
  input wire logic [31:0] rdEvenWordData, rdOddWordData,
  input wire logic [7:0] wrChkBits, rdSyndrome,
  input wire logic [63:0] rdData
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_done_follows: assert property (rdValid |=> rdDone)
    else $error("done missing");
  a_done_pulse: assert property (!rdValid |=> !rdDone)
    else $error("stray done");
  a_clean_pass: assert property (rdDone && rdSyndrome == 8'h00 |->
    !rdCorrected && rdData == $past({rdEvenWordData, rdOddWordData}))
    else $error("clean read altered");
  a_even_fatal: assert property (rdDone && !(^rdSyndrome) &&
    rdSyndrome != 8'h00 |-> rdUncorrectable) else $error("even syndrome");
  a_one_flag: assert property (rdDone |->
    !(rdCorrected && rdUncorrectable)) else $error("both flags");
  a_fix_one: assert property (rdDone && rdCorrected |->
    $countones(rdData ^ $past({rdEvenWordData, rdOddWordData})) <= 1)
    else $error("fix too wide");
  a_result_hold: assert property (!rdValid |=> $stable(rdData))
    else $error("result moved");
  a_low_addr: assert property ($stable({wrEvenWordData, wrOddWordData,
    wrAddr[31:3]}) |-> $stable(wrChkBits)) else $error("chk moved");
endmodule
bind sadec_ecc_top sadec_ecc_sva u_sva (.*);

// file: verif/sadec_ecc_tb_top.sv
// Self-checking bench for the ECC top
`timescale 1ns/10ps
module sadec_ecc_tb_top;
  logic clk = 0, sys_rst = 1, rdValid = 0, wr = 0;
  logic rdDone, rdCorrected, rdUncorrectable;
  logic [31:0] wrEvenWordData = 0, wrOddWordData = 0, wrAddr = 0;
  logic [31:0] rdEvenWordData, rdOddWordData, rdAddr = 0;
  logic [7:0] wrChkBits, rdChkBits, rdSyndrome, flipChk = 0;
  logic [63:0] rdData, flip = 0;
  int fails = 0, checked = 0;
  logic [103:0] rows [9] = '{
    104'h80000000_00000000_00000000_B0,
    104'h00000200_00000000_00000000_34,
    104'h00000000_00000001_00000000_C1,
    104'h00000000_00000000_80000000_1F,
    104'h00000000_00000000_0000000F_2F,
    104'h00000000_00000000_40000010_06,
    104'h00000000_00000000_40000008_DB,
    104'h80000000_00000000_80000000_AF,
    104'h80000000_00000000_80000007_AF};
  sadec_ecc_top dut (.*);
  sadec_mem_model mem (.*);
  always #20 clk = ~clk;
  task automatic chk(input logic [63:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [63:0] f, input logic [7:0] c,
      input logic [31:0] a, input logic [10:0] e);
    flip = f;
    flipChk = c;
    rdAddr = a;
    rdValid = 1;
    @(posedge clk) #1;
    chk({rdDone, rdCorrected, rdUncorrectable, rdSyndrome}, e);
    if (!e[8]) chk(rdData, 64'h80000000_00000000);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    tally_and_finish;
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 sys_rst = 0;
    chk({rdDone, rdCorrected, rdUncorrectable, rdSyndrome}, 0);
    chk(rdData, 0);
    foreach (rows[i]) begin
      {wrEvenWordData, wrOddWordData, wrAddr} = rows[i][103:8];
      @(posedge clk) #1;
      chk(wrChkBits, rows[i][7:0]);
    end
    wr = 1;
    @(posedge clk) #1 wr = 0;
    rd(0, 0, 32'h80000000, 11'h400);
    rd(64'h1, 0, 32'h80000000, 11'h6C1);
    rd(64'h4_0000_0000_0000, 0, 32'h80000000, 11'h610);
    rd(0, 8'h01, 32'h80000000, 11'h601);
    rd(64'h3, 0, 32'h80000000, 11'h582);
    rd(0, 0, 32'h80000008, 11'h52F);
    rd(0, 0, 32'h80000007, 11'h400);
    rdValid = 0;
    @(posedge clk) #1;
    chk(rdDone, 0);
    chk(rdData, 64'h80000000_00000000);
    // Mid-run reset clears the held result
    sys_rst = 1;
    repeat (2) @(posedge clk);
    #1 sys_rst = 0;
    chk({rdDone, rdCorrected, rdUncorrectable, rdSyndrome}, 0);
    chk(rdData, 0);
    tally_and_finish;
  end
endmodule
